// ==== hw/ssp_fifo.sv ====
// eight entry, sixteen bit queue with registered head word and count
// assumes push and pop are one-cycle strobes in the system clock domain
`timescale 1ns/100ps
module ssp_fifo import ssp_pkg::*; (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic              i_push,
  input  wire logic [DATA_W-1:0] i_push_data,
  input  wire logic              i_pop,
  output logic      [3:0]        o_count,
  output logic      [DATA_W-1:0] o_head
);

  fifo_state_s st;
  fifo_state_s next_st;
  logic        do_pop;
  logic        do_push;

  // ==========================================================================
  // next state
  always_comb begin
    next_st = st;
    do_pop  = i_pop && (st.count != 4'h0);
    // a push into a full queue fits only when a pop frees a slot this cycle
    do_push = i_push && ((st.count != DEPTH_CNT) || do_pop);
    if (do_push) begin
      next_st.mem[st.wr] = i_push_data;
      next_st.wr         = st.wr + 3'h1;
    end
    if (do_pop) begin
      next_st.rd = st.rd + 3'h1;
    end
    next_st.count = st.count + {3'h0, do_push} - {3'h0, do_pop};
    next_st.head  = next_st.mem[next_st.rd];
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_count = st.count;
  assign o_head  = st.head;

endmodule : ssp_fifo

// ==== hw/ssp_pkg.sv ====
// package for the synchronous serial port core: sizes, levels, carriers
// assumes one system clock; configuration is held steady by software
package ssp_pkg;

  // ==========================================================================
  // sizes and levels
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam logic [3:0]  DEPTH_CNT    = 4'h8;
  localparam logic [3:0]  TX_IRQ_LEVEL = 4'h4;
  localparam logic [3:0]  RX_IRQ_LEVEL = 4'h4;
  localparam logic [3:0]  DMA_TX_FREE  = 4'h4;
  localparam logic [3:0]  DMA_RX_FILL  = 4'h4;
  localparam logic [5:0]  IDLE_BITS    = 6'h20;
  localparam logic [3:0]  MIN_SIZE     = 4'h3;
  localparam logic [3:0]  MAX_SIZE     = 4'hf;
  localparam logic [7:0]  MIN_PRESCALE = 8'h02;

  // ==========================================================================
  // source bit positions
  localparam int unsigned IRQ_TX  = 3;
  localparam int unsigned IRQ_RX  = 2;
  localparam int unsigned IRQ_RT  = 1;
  localparam int unsigned IRQ_ROR = 0;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       port_enable_bit;
    logic       master;
    logic [3:0] data_size;                 // frame bits minus one
    logic [7:0] prescale;
    logic [7:0] serial_clock_rate_field;
  } port_cfg_s;

  typedef struct packed {
    logic serial_bit_clock;
    logic frame_select;
    logic serial_data_out;
    logic serial_data_out_en;
  } link_out_s;

  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_DATA, ST_TAIL} link_state_e;

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
    logic [2:0]                        wr;
    logic [2:0]                        rd;
    logic [3:0]                        count;
    logic [DATA_W-1:0]                 head;
  } fifo_state_s;

endpackage : ssp_pkg

// ==== hw/sync_serial_port.sv ====
// synchronous serial port core: pulsed-sync framing, level and event
// sources with masking, DMA request handshake
// assumes all inputs synchronous to i_sys_clk; configuration static while on
`timescale 1ns/100ps
module sync_serial_port import ssp_pkg::*; (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire port_cfg_s         i_cfg,
  input  wire logic [3:0]        i_irq_mask,
  input  wire logic              i_overrun_clear_bit,
  input  wire logic              i_timeout_clear_bit,
  input  wire logic              i_tx_dma_enable,
  input  wire logic              i_rx_dma_enable,
  input  wire logic              i_tx_dma_clear,
  input  wire logic              i_rx_dma_clear,
  input  wire logic              i_tx_write,
  input  wire logic [DATA_W-1:0] i_tx_data,
  input  wire logic              i_rx_read,
  input  wire logic              i_serial_clock_in,
  input  wire logic              i_frame_select_in,
  input  wire logic              i_serial_data_in,
  output logic      [DATA_W-1:0] o_rx_data,
  output logic      [3:0]        o_rx_count,
  output logic      [3:0]        o_tx_count,
  output logic      [3:0]        o_irq_raw,
  output logic                   o_combined_port_irq,
  output logic                   o_tx_dma_request,
  output logic                   o_rx_dma_request,
  output link_out_s              o_link
);

  typedef struct packed {
    link_state_e       state;
    logic              sclk;
    logic              sclk_in_prev;
    logic              armed;
    link_out_s         pins;
    logic [DATA_W-1:0] tx_shift;
    logic [DATA_W-1:0] rx_shift;
    logic [4:0]        bits_left;
    logic              last;
    logic [15:0]       half_cnt;
    logic [16:0]       bit_cnt;
    logic [5:0]        idle_bits;
    logic              rt;
    logic              ror;
    logic              tx_req;
    logic              rx_req;
    logic [3:0]        irq_raw;
    logic              irq_out;
  } core_state_s;

  core_state_s       st;
  core_state_s       next_st;
  logic [3:0]        tx_count;
  logic [3:0]        rx_count;
  logic [DATA_W-1:0] tx_head;
  logic              pop_tx;
  logic              push_rx;
  logic              push_try;
  logic              rise;
  logic              fall;
  logic              bit_tick;
  logic [15:0]       half;

  // ==========================================================================
  // helpers
  function automatic logic [15:0] half_period(input port_cfg_s c);
    logic [7:0] p;
    p = (c.prescale < MIN_PRESCALE) ? MIN_PRESCALE : c.prescale;
    // odd prescale values lose their low bit, as the divider cannot use it
    return {9'h0, p[7:1]} * ({8'h0, c.serial_clock_rate_field} + 16'h1);
  endfunction : half_period

  function automatic logic [3:0] eff_size(input logic [3:0] s);
    return (s < MIN_SIZE) ? MIN_SIZE : s;
  endfunction : eff_size

  // ==========================================================================
  // queues
  ssp_fifo u_tx_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_push      (i_tx_write),
    .i_push_data (i_tx_data),
    .i_pop       (pop_tx),
    .o_count     (tx_count),
    .o_head      (tx_head)
  );

  ssp_fifo u_rx_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_push      (push_rx),
    .i_push_data (st.rx_shift),
    .i_pop       (i_rx_read),
    .o_count     (rx_count),
    .o_head      (o_rx_data)
  );

  // ==========================================================================
  // next state
  always_comb begin
    next_st  = st;
    pop_tx   = 1'b0;
    push_rx  = 1'b0;
    push_try = 1'b0;
    half     = half_period(i_cfg);
    bit_tick = (st.bit_cnt >= {half, 1'b0} - 17'h1);
    rise     = 1'b0;
    fall     = 1'b0;
    next_st.sclk_in_prev = i_serial_clock_in;
    next_st.bit_cnt      = bit_tick ? 17'h0 : st.bit_cnt + 17'h1;

    // edge source: own divider as master, sampled pin as slave
    if (i_cfg.master) begin
      if (st.state != ST_IDLE) begin
        if (st.half_cnt == half - 16'h1) begin
          next_st.half_cnt = 16'h0;
          next_st.sclk     = ~st.sclk;
          rise             = ~st.sclk;
          fall             = st.sclk;
        end else begin
          next_st.half_cnt = st.half_cnt + 16'h1;
        end
      end
    end else begin
      rise = i_serial_clock_in & ~st.sclk_in_prev;
      fall = ~i_serial_clock_in & st.sclk_in_prev;
    end

    case (st.state)
      ST_IDLE: begin
        next_st.sclk     = 1'b0;
        next_st.half_cnt = 16'h0;
        if (i_cfg.port_enable_bit) begin
          if (i_cfg.master && tx_count != 4'h0) begin
            next_st.state = ST_SYNC;
            next_st.armed = 1'b0;
          end else if (!i_cfg.master && fall && i_frame_select_in) begin
            next_st.state = ST_SYNC;
            next_st.armed = 1'b1;
          end
        end
      end
      ST_SYNC: begin
        if (rise) begin
          if (!st.armed) begin
            next_st.armed             = 1'b1;
            next_st.pins.frame_select = i_cfg.master;
          end else begin
            next_st.armed             = 1'b0;
            next_st.pins.frame_select = 1'b0;
            // word enters the shifter once the sync pulse is over
            next_st.tx_shift  = tx_head <<
              (MAX_SIZE - eff_size(i_cfg.data_size));
            pop_tx            = 1'b1;
            next_st.rx_shift  = '0;
            next_st.bits_left = {1'b0, eff_size(i_cfg.data_size)} + 5'h1;
            next_st.last      = 1'b0;
            next_st.pins.serial_data_out_en = 1'b1;
            next_st.state     = ST_DATA;
            if (rx_count != DEPTH_CNT) begin
              next_st.rt        = 1'b0;
              next_st.idle_bits = 6'h0;
            end
          end
        end
      end
      ST_DATA: begin
        if (fall) begin
          next_st.rx_shift  = {st.rx_shift[DATA_W-2:0],
                               i_serial_data_in};
          next_st.bits_left = st.bits_left - 5'h1;
          next_st.last      = (st.bits_left == 5'h1);
        end else if (rise) begin
          if (st.last) begin
            push_try = 1'b1;
            if (i_cfg.master && tx_count != 4'h0) begin
              next_st.pins.frame_select = 1'b1;
              next_st.armed             = 1'b1;
              next_st.state             = ST_SYNC;
            end else if (i_cfg.master) begin
              next_st.state = ST_TAIL;
            end else begin
              next_st.state = ST_IDLE;
              next_st.pins.serial_data_out_en = 1'b0;
            end
          end else begin
            next_st.tx_shift = {st.tx_shift[DATA_W-2:0], 1'b0};
          end
        end
      end
      ST_TAIL: begin
        // let the clock fall before going quiet so no runt pulse escapes
        if (fall) begin
          next_st.state = ST_IDLE;
          next_st.pins.serial_data_out_en = 1'b0;
        end
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase

    // overrun: full queue with no read in the same cycle drops the word
    if (push_try) begin
      if (st.ror || (rx_count == DEPTH_CNT && !i_rx_read)) begin
        next_st.ror = (rx_count == DEPTH_CNT && !i_rx_read) || st.ror;
      end else begin
        push_rx = 1'b1;
      end
    end
    if (i_overrun_clear_bit && !(push_try && rx_count == DEPTH_CNT
                                 && !i_rx_read)) begin
      next_st.ror = 1'b0;
    end

    if (!i_cfg.port_enable_bit) begin
      next_st.state = ST_IDLE;
      next_st.armed = 1'b0;
      next_st.sclk  = 1'b0;
      next_st.pins.frame_select       = 1'b0;
      next_st.pins.serial_data_out_en = 1'b0;
    end

    // idle time-out; the clear loses against a set in the same cycle
    if (rx_count == 4'h0 || (st.state == ST_DATA && fall)) begin
      next_st.idle_bits = 6'h0;
    end else if (bit_tick && next_st.idle_bits == IDLE_BITS - 6'h1) begin
      next_st.idle_bits = IDLE_BITS;
    end else if (i_timeout_clear_bit) begin
      next_st.idle_bits = 6'h0;
    end else if (bit_tick && next_st.idle_bits != IDLE_BITS) begin
      // count from the frame start value so its restart is not lost
      next_st.idle_bits = next_st.idle_bits + 6'h1;
    end
    // clear works even with an empty queue
    if (i_timeout_clear_bit) begin
      next_st.rt = 1'b0;
    end
    if (next_st.idle_bits == IDLE_BITS) begin
      next_st.rt = 1'b1;
    end

    next_st.pins.serial_bit_clock = i_cfg.master & next_st.sclk;
    next_st.pins.serial_data_out  = next_st.tx_shift[DATA_W-1];

    next_st.irq_raw[IRQ_TX]  = (tx_count <= TX_IRQ_LEVEL)
                               || !i_cfg.port_enable_bit;
    next_st.irq_raw[IRQ_RX]  = (rx_count >= RX_IRQ_LEVEL);
    next_st.irq_raw[IRQ_RT]  = next_st.rt;
    next_st.irq_raw[IRQ_ROR] = next_st.ror;
    next_st.irq_out = |(next_st.irq_raw & i_irq_mask);

    // requests hold until cleared; off while port or its enable is off
    if (!i_cfg.port_enable_bit || !i_rx_dma_enable || i_rx_dma_clear) begin
      next_st.rx_req = 1'b0;
    end else if (rx_count >= DMA_RX_FILL) begin
      next_st.rx_req = 1'b1;
    end
    if (!i_cfg.port_enable_bit || !i_tx_dma_enable || i_tx_dma_clear) begin
      next_st.tx_req = 1'b0;
    end else if (DEPTH_CNT - tx_count >= DMA_TX_FREE) begin
      next_st.tx_req = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st       <= '0;
      st.state <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign o_rx_count          = rx_count;
  assign o_tx_count          = tx_count;
  assign o_irq_raw           = st.irq_raw;
  assign o_combined_port_irq = st.irq_out;
  assign o_tx_dma_request    = st.tx_req;
  assign o_rx_dma_request    = st.rx_req;
  assign o_link              = st.pins;

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence sync_end_q;
    $fell(st.pins.frame_select) && $past(i_cfg.port_enable_bit);
  endsequence
  sequence data_start_q;
    st.state == ST_DATA && st.pins.serial_data_out_en;
  endsequence

  tx_level_a: assert property ((tx_count <= TX_IRQ_LEVEL) |=>
    st.irq_raw[IRQ_TX]) else $error("transmit level source missing");
  tx_disabled_a: assert property (!i_cfg.port_enable_bit |=>
    st.irq_raw[IRQ_TX]) else $error("transmit source low while disabled");
  rx_level_a: assert property (1'b1 |=>
    st.irq_raw[IRQ_RX] == ($past(rx_count) >= RX_IRQ_LEVEL))
    else $error("receive level source wrong");
  timeout_set_a: assert property (st.idle_bits == IDLE_BITS |-> st.rt)
    else $error("time-out not raised after idle period");
  idle_empty_a: assert property (rx_count == 4'h0 |=>
    st.idle_bits == 6'h0) else $error("idle counter runs with empty queue");
  overrun_set_a: assert property (push_try && rx_count == DEPTH_CNT &&
    !i_rx_read |=> st.ror && rx_count == DEPTH_CNT)
    else $error("overrun not raised or word stored");
  read_saves_a: assert property (push_try && !st.ror &&
    rx_count == DEPTH_CNT && i_rx_read |=> rx_count == DEPTH_CNT)
    else $error("word lost although queue was read");
  irq_combine_a: assert property (1'b1 |=>
    st.irq_out == |(st.irq_raw & $past(i_irq_mask)))
    else $error("combined interrupt mismatch");
  rx_dma_set_a: assert property (i_cfg.port_enable_bit && i_rx_dma_enable
    && !i_rx_dma_clear && rx_count >= DMA_RX_FILL |=> st.rx_req)
    else $error("receive request missing");
  tx_dma_hold_a: assert property (st.tx_req && i_cfg.port_enable_bit &&
    i_tx_dma_enable && !i_tx_dma_clear |=> st.tx_req)
    else $error("transmit request dropped without clear");
  dma_off_a: assert property (!i_cfg.port_enable_bit |=>
    !st.tx_req && !st.rx_req) else $error("request while disabled");
  sync_to_data_a: assert property (sync_end_q |-> data_start_q)
    else $error("frame select fell without frame start");
  idle_pins_a: assert property (st.state == ST_IDLE |->
    !st.pins.serial_bit_clock && !st.pins.frame_select)
    else $error("link not quiet while idle");
  push_edge_a: assert property (push_rx |-> st.last && rise)
    else $error("receive push off the rising edge");

endmodule : sync_serial_port

// ==== testbench/ssp_peer_model.sv ====
// far side peer: a slave on the pulsed-sync link, replying with i_reply
// assumes the port is master and its link outputs move on i_sys_clk
`timescale 1ns/100ps
module ssp_peer_model import ssp_pkg::*; (
  input  wire logic              i_sys_clk,
  input  wire link_out_s         i_link,
  input  wire logic [3:0]        i_size,
  input  wire logic [DATA_W-1:0] i_reply,
  output logic                   o_serial_data_in,
  output logic                   o_got,
  output logic      [DATA_W-1:0] o_word
);
  logic              clk_q     = 1'b0;
  logic              sync_seen = 1'b0;
  logic              active    = 1'b0;
  logic [3:0]        nbit      = 4'h0;
  logic [DATA_W-1:0] tx_sh     = 16'h0000;
  logic [DATA_W-1:0] rx_sh     = 16'h0000;
  logic [DATA_W-1:0] aligned;

  initial begin
    o_serial_data_in = 1'b0;
    o_got            = 1'b0;
    o_word           = 16'h0000;
  end

  // ==========================================================================
  // edges of the port's bit clock, seen one system cycle late
  always @(posedge i_sys_clk) begin
    o_got <= 1'b0;
    clk_q <= i_link.serial_bit_clock;
    if (i_link.serial_bit_clock && !clk_q && sync_seen) begin
      aligned = i_reply << (4'hf - i_size);
      o_serial_data_in <= aligned[DATA_W-1];
      tx_sh            <= aligned << 1;
      rx_sh            <= 16'h0000;
      nbit             <= 4'h0;
      active           <= 1'b1;
      sync_seen        <= 1'b0;
    end else if (i_link.serial_bit_clock && !clk_q && active) begin
      o_serial_data_in <= tx_sh[DATA_W-1];
      tx_sh            <= tx_sh << 1;
    end else if (!active) begin
      // released line has no pull, so it keeps changing
      o_serial_data_in <= !o_serial_data_in;
    end
    if (!i_link.serial_bit_clock && clk_q) begin
      if (i_link.frame_select) sync_seen <= 1'b1;
      if (active) begin
        rx_sh <= {rx_sh[DATA_W-2:0], i_link.serial_data_out};
        nbit  <= nbit + 4'h1;
        if (nbit == i_size) begin
          o_got  <= 1'b1;
          o_word <= {rx_sh[DATA_W-2:0], i_link.serial_data_out};
          active <= 1'b0;
        end
      end
    end
  end
endmodule : ssp_peer_model

// ==== testbench/sync_serial_port_irq_dma_core_tb.sv ====
// self-checking bench for the serial port core with a slave peer model
// assumes one 20 MHz clock; 8 bit frames, bit period of 4 system cycles
// as master, 12 system cycles when the bench drives the link as master
`timescale 1ns/100ps
module sync_serial_port_irq_dma_core_tb import ssp_pkg::*;;
  logic        i_sys_clk, i_rst, ovr_clr, to_clr, tx_write, rx_read;
  logic        tx_dma_en, rx_dma_en, tx_dma_clr, rx_dma_clr, keep_rx;
  logic        peer_din, peer_got, irq, tx_req, rx_req;
  logic        s_clk, s_fs, s_din;
  logic [15:0] s_in, s_out;
  port_cfg_s   cfg;
  link_out_s   link;
  logic [3:0]  mask, rx_count, tx_count, irq_raw;
  logic [15:0] tx_data, reply, peer_word, rx_data;
  logic [31:0] seed = 32'hc58d;
  logic [15:0] exp_wire[$];
  logic [15:0] exp_rx[$];
  int          failures = 0;
  int          samples_checked = 0;
  int          k;

  sync_serial_port DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cfg(cfg),
    .i_irq_mask(mask), .i_overrun_clear_bit(ovr_clr),
    .i_timeout_clear_bit(to_clr), .i_tx_dma_enable(tx_dma_en),
    .i_rx_dma_enable(rx_dma_en), .i_tx_dma_clear(tx_dma_clr),
    .i_rx_dma_clear(rx_dma_clr), .i_tx_write(tx_write), .i_tx_data(tx_data),
    .i_rx_read(rx_read), .i_serial_clock_in(s_clk), .i_frame_select_in(s_fs),
    .i_serial_data_in(cfg.master ? peer_din : s_din),
    .o_rx_data(rx_data), .o_rx_count(rx_count),
    .o_tx_count(tx_count), .o_irq_raw(irq_raw), .o_combined_port_irq(irq),
    .o_tx_dma_request(tx_req), .o_rx_dma_request(rx_req), .o_link(link));

  ssp_peer_model peer (.i_sys_clk(i_sys_clk), .i_link(link),
    .i_size(cfg.data_size), .i_reply(reply), .o_serial_data_in(peer_din),
    .o_got(peer_got), .o_word(peer_word));

  // ==========================================================================
  // helpers
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : xs

  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : chk

  // keep = 0 for a write that the full queue must refuse
  task automatic wr(input logic keep);
    tx_data  = xs();
    tx_write = 1'b1;
    if (keep) exp_wire.push_back(tx_data & 16'h00ff);
    tick();
    tx_write = 1'b0;
    tick();
  endtask : wr

  task automatic rd();
    rx_read = 1'b1;
    tick();
    rx_read = 1'b0;
    tick();
  endtask : rd

  task automatic wait_sent();
    for (k = 0; k < 3000 && exp_wire.size() != 0; k++) tick();
    tick(20);
    chk(exp_wire.size(), 0, "frames not all sent");
  endtask : wait_sent

  task automatic tally_and_finish();
    $display("checked %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // clock, watchdog, result monitor
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    #(50 * 20000);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  always @(posedge i_sys_clk) begin
    if (peer_got) begin
      chk(peer_word, exp_wire.size() ? exp_wire.pop_front() : 16'hxxxx,
          "word on wire");
      if (keep_rx) exp_rx.push_back(reply & 16'h00ff);
      reply <= xs();
    end
    if (rx_read && rx_count != 4'h0)
      chk(rx_data, exp_rx.size() ? exp_rx.pop_front() : 16'hxxxx,
          "received word");
  end

  // ==========================================================================
  // main sequence
  initial begin
    i_rst = 1'b1;
    cfg = '0;
    cfg.prescale = 8'h04;
    cfg.data_size = 4'h7;
    {mask, ovr_clr, to_clr, tx_write, rx_read, tx_dma_clr, rx_dma_clr} = '0;
    {tx_dma_en, rx_dma_en, keep_rx} = 3'b111;
    {s_clk, s_fs, s_din} = 3'b000;
    tx_data = 16'h0000;
    reply = xs();
    repeat (12) @(posedge i_sys_clk);
    #1 i_rst = 1'b0;
    tick(2);
    chk(irq_raw[3], 1, "tx level while off");
    chk(tx_req, 0, "tx dma while off");
    wr(1);
    cfg.port_enable_bit = 1'b1;
    tick(2);
    for (int n = 2; n <= 5; n++) begin
      wr(1);
      tick(2);
      chk(tx_count, n, "tx count");
      chk(irq_raw[3], n <= 4, "tx level");
      if (n == 4) chk(tx_req, 1, "tx dma at 4 free");
    end
    tx_dma_clr = 1'b1;
    tick(3);
    chk(tx_req, 0, "tx dma during clear");
    tx_dma_clr = 1'b0;
    tick(3);
    chk(tx_req, 0, "tx dma with 3 free");
    cfg.port_enable_bit = 1'b0;
    tick(2);
    chk(irq_raw[3], 1, "tx level off, 5 queued");
    repeat (3) wr(1);
    wr(0);
    tick(2);
    chk(tx_count, 8, "full tx refuses");
    $display("test levels done");
    cfg.master = 1'b1;
    tick();
    cfg.port_enable_bit = 1'b1;
    wait_sent();
    chk(rx_count, 8, "rx filled");
    chk(irq_raw[2], 1, "rx level");
    chk(rx_req, 1, "rx dma");
    chk(irq_raw[1], 0, "no early timeout");
    chk(link & 4'b1101, 4'h0, "idle link");
    rx_dma_clr = 1'b1;
    tick(3);
    chk(rx_req, 0, "rx dma during clear");
    rx_dma_clr = 1'b0;
    tick(3);
    chk(rx_req, 1, "rx dma again");
    tick(60);
    chk(irq_raw[1], 0, "timeout too soon");
    tick(80);
    chk(irq_raw[1], 1, "timeout");
    mask = 4'b0010;
    tick(2);
    chk(irq, 1, "combined timeout");
    mask = 4'b0001;
    tick(2);
    chk(irq, 0, "masked timeout");
    $display("test frames done");
    keep_rx = 1'b0;
    wr(1);
    wait_sent();
    chk(irq_raw[0], 1, "overrun");
    chk(irq_raw[1], 1, "timeout kept when full");
    chk(rx_count, 8, "word discarded");
    chk(irq, 1, "combined overrun");
    {ovr_clr, to_clr} = 2'b11;
    tick();
    {ovr_clr, to_clr} = 2'b00;
    tick(2);
    chk(irq_raw[0], 0, "overrun cleared");
    keep_rx = 1'b1;
    wr(1);
    for (k = 0; k < 500 && link.frame_select !== 1'b1; k++) tick();
    while (k < 500 && link.frame_select !== 1'b0) begin
      k++;
      tick();
    end
    chk(k < 500, 1, "no sync pulse seen");
    rd();
    wait_sent();
    chk(rx_count, 8, "read during ninth keeps word");
    chk(irq_raw[0], 0, "no overrun");
    rx_dma_en = 1'b0;
    tick(2);
    chk(rx_req, 0, "rx dma disabled");
    repeat (8) rd();
    tick(2);
    chk(rx_count, 0, "rx drained");
    chk(irq_raw[2], 0, "rx level low");
    chk(exp_rx.size(), 0, "rx words left");
    $display("test overrun done");
    cfg.port_enable_bit = 1'b0;
    tick();
    cfg.master = 1'b0;
    wr(1);
    cfg.port_enable_bit = 1'b1;
    s_in = xs();
    s_out = 16'h0000;
    tick(2);
    {s_fs, s_clk} = 2'b11;
    tick(6);
    s_clk = 1'b0;
    tick(6);
    s_fs = 1'b0;
    for (k = 7; k >= 0; k--) begin
      {s_clk, s_din} = {1'b1, s_in[k]};
      tick(6);
      s_out[k] = link.serial_data_out;
      s_clk = 1'b0;
      tick(6);
    end
    exp_rx.push_back(s_in & 16'h00ff);
    s_clk = 1'b1;
    tick(6);
    s_clk = 1'b0;
    tick(2);
    chk(s_out, exp_wire.pop_front(), "slave word out");
    chk(rx_count, 1, "slave word in");
    chk(link & 4'b1101, 4'h0, "slave idle link");
    rd();
    tick(2);
    chk(exp_rx.size(), 0, "slave rx word left");
    $display("test slave done");
    tally_and_finish();
  end
endmodule : sync_serial_port_irq_dma_core_tb
